//--- design/fps_device.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// Flash sequencer, device end
// ********************************************************************
module fps_device
    import fps_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    // Bus side
    fps_if.device                      bus,
    // Array side
    input  wire logic                  boot_block_protect,
    input  wire logic                  programming_supply,
    input  wire logic [FPS_DATA_W-1:0] cell_rdata,
    output logic [FPS_ADDR_W-1:0]      cell_addr,
    output logic [FPS_DATA_W-1:0]      cell_wdata,
    output logic                       cell_hv_on,
    output logic                       cell_program
);

    logic       erase_select;          // Erase mode chosen
    logic       program_latch_enable;  // Latches open
    logic       high_voltage_apply;    // Software HV request
    logic       latched;               // Write captured since latch set
    logic       hv_ok;                 // Latched location may be pulsed

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            erase_select         <= 1'b0;
            program_latch_enable <= 1'b0;
            high_voltage_apply   <= 1'b0;
        end else if (bus.ctl_we) begin
            erase_select         <= bus.ctl_wdata[FPS_BIT_ERS];
            program_latch_enable <= bus.ctl_wdata[FPS_BIT_PLE];
            high_voltage_apply   <= bus.ctl_wdata[FPS_BIT_HVA];
        end
    end

    // Readback of control and supply status
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bus.ctl_rdata <= FPS_CTL_RESET;
        end else begin
            bus.ctl_rdata <= {4'h0, programming_supply, erase_select,
                              program_latch_enable, high_voltage_apply};
        end
    end

    // ****************************************************************
    // Address and data latches
    // ****************************************************************
    logic in_array;  // Address inside the array
    logic in_boot;   // Address inside the boot block
    assign in_array = (bus.arr_addr >= FPS_ARRAY_BASE) &&
                      (bus.arr_addr <= FPS_ARRAY_LAST);
    assign in_boot  = (bus.arr_addr >= FPS_BOOT_BASE) &&
                      (bus.arr_addr <= FPS_BOOT_LAST);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cell_addr  <= '0;
            cell_wdata <= '0;
            latched    <= 1'b0;
        end else if (!program_latch_enable || erase_select) begin
            // Latches closed; a fresh write is needed next time
            latched <= 1'b0;
        end else if (bus.arr_we && in_array &&
                     !(boot_block_protect && in_boot) &&
                     !high_voltage_apply) begin
            // Latch held steady while HV is on
            cell_addr  <= bus.arr_addr;
            cell_wdata <= bus.arr_wdata;
            latched    <= 1'b1;
        end
    end

    assign hv_ok = program_latch_enable && !erase_select && latched;

    // ****************************************************************
    // High voltage
    // ****************************************************************
    // Voltage follows the bit one cycle late, only while hv_ok holds
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cell_hv_on   <= 1'b0;
            cell_program <= 1'b0;
        end else begin
            cell_hv_on   <= high_voltage_apply && hv_ok;
            cell_program <= hv_ok;
        end
    end

    // ****************************************************************
    // Array readback
    // ****************************************************************
    // One cycle read answer from the cell data
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bus.arr_rdata  <= '0;
            bus.arr_rvalid <= 1'b0;
        end else begin
            bus.arr_rdata  <= cell_rdata;
            bus.arr_rvalid <= bus.arr_re;
        end
    end

endmodule
`default_nettype wire

//--- design/fps_host.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Clear erase, set latch: program mode
// - Array write latches address and data
// - Protected boot block writes are ignored
// - HV bit set applies, clear removes
// - Hold HV for pulse time
// - Wait HV turn off before read
// - Read, repeat pulses up to maximum
// - Repeat same pulse count for margin
// - Clear latch; restart for next location
module fps_host
    import fps_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    // Link to device
    fps_if.host                        bus,
    // User request
    input  wire logic                  req_valid,
    input  wire logic [FPS_ADDR_W-1:0] req_addr,
    input  wire logic [FPS_DATA_W-1:0] req_data,
    // User status
    output logic                       busy,
    output logic                       done,
    output logic                       fail,
    output logic [FPS_NPP_W-1:0]       pulses_used
);

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [3:0] {
        S_IDLE   = 4'b0000,  // Waiting for request
        S_MODE   = 4'b0001,  // Write latch enable
        S_WRITE  = 4'b0011,  // Write array location
        S_HVON   = 4'b0010,  // Set HV bit
        S_PULSE  = 4'b0110,  // Hold pulse
        S_HVOFF  = 4'b0111,  // Clear HV bit, settle
        S_READ   = 4'b0101,  // Issue read
        S_CHECK  = 4'b0100,  // Compare readback
        S_CLEAR  = 4'b1100,  // Clear latch enable
        S_FAIL   = 4'b1101   // Give up
    } fps_state_e;

    fps_state_e                state;      // Current state
    logic [FPS_ADDR_W-1:0]     tgt_addr;   // Location being programmed
    logic [FPS_DATA_W-1:0]     tgt_data;   // Value wanted there
    logic [FPS_CNT_W-1:0]      dly;        // Delay counter
    logic [FPS_NPP_W-1:0]      npp;        // Pulses applied, then margin pulses left
    logic                      margin;     // Margin phase active
    logic                      wait_read;  // Read outstanding

    localparam logic [FPS_CNT_W-1:0] PULSE_CNT = FPS_CNT_W'(FPS_PULSE_CYC);
    localparam logic [FPS_CNT_W-1:0] OFF_CNT   = FPS_CNT_W'(FPS_HV_OFF_CYC);
    localparam logic [FPS_NPP_W-1:0] MAX_NPP   = FPS_NPP_W'(FPS_MAX_PULSES);
    localparam logic [7:0] CTL_PROG = 8'h02;  // Latch only
    localparam logic [7:0] CTL_HV   = 8'h03;  // Latch and HV
    localparam logic [7:0] CTL_OFF  = 8'h00;  // All clear

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // One location per request; pulse counts live in npp
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state         <= S_IDLE;
            tgt_addr      <= '0;
            tgt_data      <= '0;
            dly           <= '0;
            npp           <= '0;
            margin        <= 1'b0;
            wait_read     <= 1'b0;
            busy          <= 1'b0;
            done          <= 1'b0;
            fail          <= 1'b0;
            pulses_used   <= '0;
            bus.ctl_wdata <= CTL_OFF;
            bus.ctl_we    <= 1'b0;
            bus.arr_addr  <= '0;
            bus.arr_wdata <= '0;
            bus.arr_we    <= 1'b0;
            bus.arr_re    <= 1'b0;
        end else begin
            bus.ctl_we <= 1'b0;
            bus.arr_we <= 1'b0;
            bus.arr_re <= 1'b0;
            done       <= 1'b0;
            unique case (state)
                // New request; stale status cleared so it cannot mislead
                S_IDLE: begin
                    if (req_valid) begin
                        pulses_used <= '0;
                        tgt_addr <= req_addr;
                        tgt_data <= req_data;
                        npp      <= '0;
                        margin   <= 1'b0;
                        busy     <= 1'b1;
                        fail     <= 1'b0;
                        state    <= S_MODE;
                    end
                end
                S_MODE: begin
                    bus.ctl_wdata <= CTL_PROG;
                    bus.ctl_we    <= 1'b1;
                    state         <= S_WRITE;
                end
                S_WRITE: begin
                    bus.arr_addr  <= tgt_addr;
                    bus.arr_wdata <= tgt_data;
                    bus.arr_we    <= 1'b1;
                    state         <= S_HVON;
                end
                S_HVON: begin
                    bus.ctl_wdata <= CTL_HV;
                    bus.ctl_we    <= 1'b1;
                    dly           <= PULSE_CNT;
                    state         <= S_PULSE;
                end
                S_PULSE: begin
                    if (dly == 1) begin
                        bus.ctl_wdata <= CTL_PROG;
                        bus.ctl_we    <= 1'b1;
                        dly           <= OFF_CNT;
                        state         <= S_HVOFF;
                    end else begin
                        dly <= dly - 1'b1;
                    end
                end
                S_HVOFF: begin
                    if (dly == 1) begin
                        state <= S_READ;
                    end else begin
                        dly <= dly - 1'b1;
                    end
                end
                // Read back after each pulse
                // Counts up while verifying, down through margin pulses
                S_READ: begin
                    bus.arr_addr <= tgt_addr;
                    bus.arr_re   <= 1'b1;
                    wait_read    <= 1'b1;
                    if (margin) begin
                        npp <= npp - 1'b1;
                    end else begin
                        npp <= npp + 1'b1;
                    end
                    state <= S_CHECK;
                end
                // Judge the readback once its answer stands
                S_CHECK: begin
                    if (wait_read && bus.arr_rvalid) begin
                        wait_read <= 1'b0;
                        if (margin) begin
                            if (npp != '0) begin
                                state <= S_HVON;
                            end else if (bus.arr_rdata == tgt_data) begin
                                state <= S_CLEAR;
                            end else begin
                                state <= S_FAIL;
                            end
                        end else if (bus.arr_rdata == tgt_data) begin
                            margin      <= 1'b1;
                            pulses_used <= npp;
                            state       <= S_HVON;
                        end else if (npp < MAX_NPP) begin
                            state <= S_HVON;
                        end else begin
                            // Report how many pulses were spent
                            pulses_used <= npp;
                            state       <= S_FAIL;
                        end
                    end
                end
                S_CLEAR: begin
                    bus.ctl_wdata <= CTL_OFF;
                    bus.ctl_we    <= 1'b1;
                    busy          <= 1'b0;
                    done          <= 1'b1;
                    state         <= S_IDLE;
                end
                // Give up; latches closed as on success
                S_FAIL: begin
                    bus.ctl_wdata <= CTL_OFF;
                    bus.ctl_we    <= 1'b1;
                    busy          <= 1'b0;
                    done          <= 1'b1;
                    fail          <= 1'b1;
                    state         <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- design/fps_if.sv
`timescale 1ns/10ps
`default_nettype none
// Link between the programming controller and the flash sequencer
interface fps_if
    import fps_pkg::*;
();
    logic [7:0]            ctl_wdata;  // Control register write value
    logic                  ctl_we;     // Control register write strobe
    logic [7:0]            ctl_rdata;  // Control register readback
    logic [FPS_ADDR_W-1:0] arr_addr;   // Array address
    logic [FPS_DATA_W-1:0] arr_wdata;  // Array write data
    logic                  arr_we;     // Array write strobe
    logic                  arr_re;     // Array read strobe
    logic [FPS_DATA_W-1:0] arr_rdata;  // Array read data
    logic                  arr_rvalid; // Read data valid

    modport device (
        input  ctl_wdata, ctl_we, arr_addr, arr_wdata, arr_we, arr_re,
        output ctl_rdata, arr_rdata, arr_rvalid
    );
    modport host (
        output ctl_wdata, ctl_we, arr_addr, arr_wdata, arr_we, arr_re,
        input  ctl_rdata, arr_rdata, arr_rvalid
    );
endinterface
`default_nettype wire

//--- design/fps_pkg.sv
`default_nettype none
package fps_pkg;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int unsigned FPS_ADDR_W = 16;          // Array byte address
    localparam int unsigned FPS_DATA_W = 8;           // One byte per location
    localparam logic [15:0] FPS_ARRAY_BASE = 16'h8000; // First array byte
    localparam logic [15:0] FPS_ARRAY_LAST = 16'hffff; // Last array byte
    localparam logic [15:0] FPS_BOOT_BASE  = 16'hf800; // Boot block start
    localparam logic [15:0] FPS_BOOT_LAST  = 16'hffff; // Boot block end

    // ****************************************************************
    // Control register bit positions
    // ****************************************************************
    localparam int unsigned FPS_BIT_HVA  = 0;  // high_voltage_apply
    localparam int unsigned FPS_BIT_PLE  = 1;  // program_latch_enable
    localparam int unsigned FPS_BIT_ERS  = 2;  // erase_select
    localparam int unsigned FPS_BIT_SUP  = 3;  // programming_supply ok
    localparam logic [7:0]  FPS_CTL_RESET = 8'h00; // All bits clear

    // ****************************************************************
    // Timing of the programming routine
    // ****************************************************************
    localparam int unsigned FPS_CLK_HZ = 25_000_000;   // clk_sys rate
    localparam int unsigned FPS_PULSE_US = 25;         // program_pulse_time
    localparam int unsigned FPS_HV_OFF_US = 10;        // high_voltage_off_delay
    // Times scale by clk_sys in whole MHz; any fraction is dropped
    localparam int unsigned FPS_PULSE_CYC =
        (FPS_PULSE_US * (FPS_CLK_HZ / 1_000_000));
    localparam int unsigned FPS_HV_OFF_CYC =
        (FPS_HV_OFF_US * (FPS_CLK_HZ / 1_000_000));
    localparam int unsigned FPS_MAX_PULSES = 50;       // max_program_pulses
    localparam int unsigned FPS_CNT_W = 10;            // Delay counter width
    localparam int unsigned FPS_NPP_W = 6;             // Pulse counter width

endpackage
`default_nettype wire

//--- verification/flash_program_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Bench top
// ****************************************************************
module flash_program_sequencer_tb
    import fps_pkg::*;
();
    logic        clk_sys, sys_rst;     // Clock, reset
    logic        req_valid;            // Host request
    logic [15:0] req_addr, seen_addr;  // Request, last latched address
    logic [7:0]  req_data, seen_data;  // Request, last latched data
    logic        busy, done, fail;     // Host status
    logic [5:0]  pulses_used;          // Host pulse count
    logic [15:0] cell_addr, addr_f;    // Latched address, both devices
    logic [7:0]  cell_wdata, cell_rdata; // Array cell model
    logic        cell_hv_on, cell_program, hv_d; // Array controls
    logic        prot_f, hv_f, prog_f; // Fault device pins
    int          need, err_count, checks_done; // Scenario state, tallies
    int          pc = 0;               // Pulses seen by the cell model
    int          hv_rises = 0;         // HV rises seen, never reset
    fps_if bus_if();                   // Host to device
    fps_if fault_if();                 // Bench to second device
    fps_device fps_device_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .bus(bus_if), .boot_block_protect(1'b0), .programming_supply(1'b1),
        .cell_rdata(cell_rdata), .cell_addr(cell_addr),
        .cell_wdata(cell_wdata), .cell_hv_on(cell_hv_on),
        .cell_program(cell_program));
    fps_host fps_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus_if),
        .req_valid(req_valid), .req_addr(req_addr), .req_data(req_data),
        .busy(busy), .done(done), .fail(fail), .pulses_used(pulses_used));
    // Second device is driven wrongly on purpose
    fps_device fault_fps_device_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .bus(fault_if), .boot_block_protect(prot_f),
        .programming_supply(1'b1), .cell_rdata(8'hff), .cell_addr(addr_f),
        .cell_wdata(), .cell_hv_on(hv_f), .cell_program(prog_f));
    fps_props fps_props_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .ctl_wdata(bus_if.ctl_wdata), .ctl_we(bus_if.ctl_we),
        .ctl_rdata(bus_if.ctl_rdata), .arr_addr(bus_if.arr_addr),
        .arr_we(bus_if.arr_we), .arr_re(bus_if.arr_re),
        .arr_rvalid(bus_if.arr_rvalid));
    // Cell reads erased until it has taken need pulses
    assign cell_rdata = (pc >= need) ? cell_wdata : 8'hff;
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Cell model counts pulses, notes what was latched
    always @(posedge clk_sys) begin
        hv_d <= cell_hv_on;
        if (!cell_program) begin
            pc <= 0;
        end else if (cell_hv_on && !hv_d) begin
            pc <= pc + 1;
        end
        if (cell_hv_on && !hv_d) begin
            hv_rises <= hv_rises + 1;
            seen_addr <= cell_addr;
            seen_data <= cell_wdata;
        end
    end
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One host request, judged at done
    task automatic run_prog(input logic [15:0] a, input logic [7:0] d,
        input int n, input logic xf, input logic [5:0] xp, input int xr);
        int i;
        int hv0;
        need = n;
        hv0 = hv_rises;
        @(posedge clk_sys);
        req_addr  <= a;
        req_data  <= d;
        req_valid <= 1'b1;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        for (i = 0; i < 50000 && done !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(done === 1'b1, "no done");
        chk(fail === xf, "fail flag");
        chk(pulses_used === xp, "pulse count");
        chk(hv_rises - hv0 == xr, "pulses on array");
        chk(xf || (seen_addr === a && seen_data === d), "latch");
        @(posedge clk_sys);
        #1;
        chk(done === 1'b0 && busy === 1'b0, "done lasts");
    endtask
    // Drive one strobe on the fault link
    task automatic fctl(input logic [7:0] v);
        @(posedge clk_sys);
        fault_if.ctl_wdata <= v;
        fault_if.ctl_we    <= 1'b1;
        @(posedge clk_sys);
        fault_if.ctl_we    <= 1'b0;
    endtask
    task automatic farr(input logic [15:0] a);
        @(posedge clk_sys);
        fault_if.arr_addr <= a;
        fault_if.arr_we   <= 1'b1;
        @(posedge clk_sys);
        fault_if.arr_we   <= 1'b0;
    endtask
    // Mode, write, HV on; then HV off and latch clear
    task automatic fault_case(input logic [7:0] c1, input logic [15:0] a,
        input logic p, input logic [7:0] chv, input logic x);
        @(posedge clk_sys);
        prot_f <= p;
        fctl(c1);
        farr(a);
        fctl(chv);
        @(posedge clk_sys);
        #1;
        chk(hv_f === x, "HV gate");
        chk(fault_if.ctl_rdata[2:1] === chv[2:1], "ctl readback");
        chk(!x || (prog_f === 1'b1 && addr_f === a), "latched");
        fctl(c1);
        @(posedge clk_sys);
        #1;
        chk(hv_f === 1'b0, "HV not removed");
        fctl(8'h00);
    endtask
    task automatic test_reset();
        @(posedge clk_sys);
        #1;
        chk(bus_if.ctl_rdata[2:0] === FPS_CTL_RESET[2:0], "ctl reset");
        chk(bus_if.ctl_rdata[3] === 1'b1, "supply status");
        chk(busy === 1'b0 && fail === 1'b0, "rst status");
        chk(cell_hv_on === 1'b0, "rst HV");
        $display("test reset finished");
    endtask
    task automatic test_single();
        run_prog(16'h8000, 8'h5a, 1, 1'b0, 6'd1, 2);
        $display("test single finished");
    endtask
    task automatic test_margin();
        run_prog(16'h8001, 8'ha5, 3, 1'b0, 6'd3, 6);
        run_prog(16'hf7ff, 8'h00, 2, 1'b0, 6'd2, 4);
        $display("test margin finished");
    endtask
    task automatic test_max_fail();
        run_prog(16'h8003, 8'h3c, 99, 1'b1, 6'd50, 50);
        $display("test max pulses finished");
    endtask
    task automatic test_faults();
        fault_case(8'h02, 16'h8000, 1'b0, 8'h03, 1'b1);
        fault_case(8'h02, 16'hf800, 1'b1, 8'h03, 1'b0);
        fault_case(8'h02, 16'hffff, 1'b0, 8'h03, 1'b1);
        fault_case(8'h06, 16'h8000, 1'b0, 8'h07, 1'b0);
        fault_case(8'h02, 16'h7fff, 1'b0, 8'h03, 1'b0);
        fault_case(8'h00, 16'h8000, 1'b0, 8'h01, 1'b0);
        $display("test faults finished");
    endtask
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_addr = 16'h0000;
        req_data = 8'h00;
        prot_f = 1'b0;
        {err_count, checks_done, need} = '0;
        fault_if.ctl_wdata = 8'h00;
        fault_if.ctl_we = 1'b0;
        fault_if.arr_addr = 16'h0000;
        fault_if.arr_wdata = 8'h3c;
        fault_if.arr_we = 1'b0;
        fault_if.arr_re = 1'b0;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        test_reset();
        test_single();
        test_margin();
        test_max_fail();
        test_faults();
        tally_and_finish();
    end
    // Watchdog: about 62 pulses of 900 cycles plus slack
    initial begin
        repeat (90000) @(posedge clk_sys);
        err_count++;
        $display("mismatch at %0t: watchdog", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire

//--- verification/fps_props.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Link checker
// ****************************************************************
module fps_props
    import fps_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Link signals
    input  wire logic [7:0]  ctl_wdata,
    input  wire logic        ctl_we,
    input  wire logic [7:0]  ctl_rdata,
    input  wire logic [15:0] arr_addr,
    input  wire logic        arr_we,
    input  wire logic        arr_re,
    input  wire logic        arr_rvalid
);
    // Off floor; one cycle slack since readback lags the write
    localparam int OFF_MIN = 249;
    int unsigned hv_cnt;   // Cycles HV has stood
    int unsigned off_cnt;  // Cycles since HV fell
    int unsigned pls;      // Pulses on this location
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Length of the running pulse
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !ctl_rdata[0]) begin
            hv_cnt <= 0;
        end else begin
            hv_cnt <= hv_cnt + 1;
        end
    end
    // Off time, saturates so it cannot wrap
    always_ff @(posedge clk_sys) begin
        if (sys_rst || ctl_rdata[0]) begin
            off_cnt <= 0;
        end else if (off_cnt < 1000) begin
            off_cnt <= off_cnt + 1;
        end
    end
    // Pulse rises while latch stands
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !ctl_rdata[1]) begin
            pls <= 0;
        end else if (ctl_rdata[0] && hv_cnt == 0) begin
            pls <= pls + 1;
        end
    end
    read_answer_a: assert property (arr_re |=> arr_rvalid)
        else $error("read answer missing");
    read_lone_a: assert property (!arr_re |=> !arr_rvalid)
        else $error("read answer without read");
    // Readback lags a strobe by two edges: register, then copy
    ctl_readback_a: assert property (ctl_we |-> ##2
        ctl_rdata[2:0] == $past(ctl_wdata[2:0], 2))
        else $error("ctl readback");
    ctl_hold_a: assert property (!ctl_we |-> ##2
        $stable(ctl_rdata[2:0])) else $error("ctl changed unwritten");
    pulse_length_a: assert property ($fell(ctl_rdata[0]) |->
        hv_cnt == FPS_PULSE_CYC) else $error("pulse length");
    off_wait_a: assert property (arr_re |-> off_cnt >= OFF_MIN)
        else $error("read before HV off");
    hv_mode_a: assert property (ctl_rdata[0] |->
        ctl_rdata[1] && !ctl_rdata[2]) else $error("HV outside mode");
    // Mode write shows in readback one edge after the array write
    write_mode_a: assert property (arr_we |->
        (arr_addr >= FPS_ARRAY_BASE) ##1 (ctl_rdata[1] && !ctl_rdata[0]))
        else $error("bad write");
    latch_clear_a: assert property (ctl_we && !ctl_wdata[1] |->
        !ctl_rdata[0]) else $error("latch cleared under HV");
    pulse_cap_a: assert property (pls <= 2 * FPS_MAX_PULSES)
        else $error("too many pulses");
endmodule
`default_nettype wire
